// ### hw/clock_divider.sv
// divided clock output generator
`default_nettype none
module clock_divider #(
	parameter int RATIO = irq_sync_pkg::DIV_RATIO_4
) (
	input  wire logic i_clk,     // clock
	input  wire logic i_resetn,  // sync reset, active low
	input  wire logic i_enable,  // run the divider
	output logic      o_div_clk  // divided clock, registered
);
	localparam int HALF = RATIO / 2;
	localparam int CW   = (HALF > 1) ? $clog2(HALF) : 1;
	localparam logic [CW-1:0] LAST = CW'(HALF - 1);

	typedef struct packed {
		logic [CW-1:0] count;
		logic          level;
	} div_state_type;

	div_state_type s;
	div_state_type next_s;

	always_comb begin
		next_s = s;
		if (!i_enable) begin
			// reserved ratio parks the output low
			next_s.count = '0;
			next_s.level = 1'b0;
		end else if (s.count == LAST) begin
			next_s.count = '0;
			next_s.level = ~s.level;
		end else begin
			next_s.count = s.count + CW'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_div_clk = s.level;
endmodule // clock_divider
`default_nettype wire

// ### hw/irq_sync_pkg.sv
// constants shared by the control register slice
`default_nettype none
package irq_sync_pkg;
	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int          AXI_ADDR_W = 12;
	localparam int          AXI_DATA_W = 32;
	localparam int          IDX_W      = 9;
	localparam int          REG_W      = 8;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_SYSREF_CONTROL   = 9'h03A;
	localparam logic [IDX_W-1:0] IDX_CLOCK_RATIO      = 9'h0F8;
	localparam logic [IDX_W-1:0] IDX_SCRATCH_SPARE    = 9'h0F9;
	localparam logic [IDX_W-1:0] IDX_SHADOW_TRANSFER  = 9'h0FF;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS       = 9'h100;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK         = 9'h101;
	localparam logic [IDX_W-1:0] IDX_IRQ_PENDING      = 9'h102;
	localparam logic [IDX_W-1:0] IDX_DIGITAL_CONTROL  = 9'h105;
	localparam logic [IDX_W-1:0] IDX_CAL_THRESH_CTRL  = 9'h10A;
	localparam logic [IDX_W-1:0] IDX_CAL_THRESH_A     = 9'h10D;
	localparam logic [IDX_W-1:0] IDX_CAL_THRESH_B     = 9'h10E;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [REG_W-1:0] RST_CLOCK_RATIO     = 8'h00;
	localparam logic [REG_W-1:0] RST_SCRATCH_SPARE   = 8'h00;
	localparam logic [REG_W-1:0] RST_IRQ_MASK        = 8'h00;
	localparam logic [REG_W-1:0] RST_DIGITAL_CONTROL = 8'h00;
	localparam logic [REG_W-1:0] RST_CAL_THRESH_CTRL = 8'h10;
	localparam logic [REG_W-1:0] RST_CAL_THRESH_A    = 8'h3D;
	localparam logic [REG_W-1:0] RST_CAL_THRESH_B    = 8'h14;
	localparam logic [REG_W-1:0] RST_SYSREF_CONTROL  = 8'h00;
	// ----------------------------------------------------------------
	// field positions and writable masks
	// ----------------------------------------------------------------
	localparam int               BIT_RATIO_SEL     = 0;
	localparam int               BIT_TRANSFER      = 0;
	localparam int               BIT_PLL_UNLOCK    = 7;
	localparam int               BIT_SYSREF_HOLD   = 3;
	localparam int               BIT_SYSREF_SETUP  = 2;
	localparam int               BIT_CLOCK_ERR     = 0;
	localparam int               BIT_CAL_THRESH_EN = 4;
	localparam int               BIT_SYSREF_CLEAR  = 6;
	localparam logic [REG_W-1:0] MASK_IRQ_BITS     = 8'h8D;
	localparam logic [REG_W-1:0] MASK_IRQ_MASK_RW  = 8'hBD;
	localparam logic [REG_W-1:0] MASK_DIGITAL_RW   = 8'h1F;
	localparam logic [REG_W-1:0] MASK_CAL_CTRL_RW  = 8'h10;
	localparam logic [REG_W-1:0] MASK_SYSREF_RW    = 8'h40;
	localparam logic [REG_W-1:0] MASK_TRANSFER_RW  = 8'h01;
	// ----------------------------------------------------------------
	// divided clock output
	// ----------------------------------------------------------------
	localparam int               DIV_RATIO_4 = 4;
	localparam logic             RATIO_SEL_DIV4 = 1'b0;
endpackage
`default_nettype wire

// ### hw/irq_sync_regs.sv
// control register slice: clock ratio, spares, transfer, irq, calibration thresholds
//
// Summary of operation
// - ratio bit 0 clear selects divide by four, set parks the divided clock low
// - transfer bit copies master to active, self-clears
// - status bit 7 shows PLL out of lock
// - SYSREF hold and setup errors stay sticky
// - set-then-clear sysref bit 6 clears both errors
// - status bit 0 shows clock error
// - mask bit 7 suppresses PLL unlock interrupt
// - mask bits 3,2 gate SYSREF error interrupts
// - mask bit 0 gates clock error interrupt
// - clock error clears only by device reset
// - control bit 4 enables threshold logic, default on
// - two threshold registers reset to 3D, 14
`default_nettype none
module irq_sync_regs (
	input  wire logic                                 i_clk,              // 100 MHz clock
	input  wire logic                                 i_resetn,           // sync reset, low
	input  wire logic                                 i_awvalid,          // write address valid
	output logic                                      o_awready,          // write address ready
	input  wire logic [irq_sync_pkg::AXI_ADDR_W-1:0]  i_awaddr,           // write byte address
	input  wire logic                                 i_wvalid,           // write data valid
	output logic                                      o_wready,           // write data ready
	input  wire logic [irq_sync_pkg::AXI_DATA_W-1:0]  i_wdata,            // write data
	input  wire logic [3:0]                           i_wstrb,            // byte strobes
	output logic                                      o_bvalid,           // write response valid
	input  wire logic                                 i_bready,           // write response ready
	output logic      [1:0]                           o_bresp,            // write response
	input  wire logic                                 i_arvalid,          // read address valid
	output logic                                      o_arready,          // read address ready
	input  wire logic [irq_sync_pkg::AXI_ADDR_W-1:0]  i_araddr,           // read byte address
	output logic                                      o_rvalid,           // read data valid
	input  wire logic                                 i_rready,           // read data ready
	output logic      [irq_sync_pkg::AXI_DATA_W-1:0]  o_rdata,            // read data
	output logic      [1:0]                           o_rresp,            // read response
	input  wire logic                                 i_pll_unlocked,     // PLL out of lock
	input  wire logic                                 i_sysref_setup_err, // setup violation
	input  wire logic                                 i_sysref_hold_err,  // hold violation
	input  wire logic                                 i_clock_err,        // clock fault
	output logic                                      o_irq,              // interrupt level
	output logic                                      o_divided_clock_output, // divided clock
	output logic                                      o_data_invalid,     // data not trusted
	output logic      [irq_sync_pkg::REG_W-1:0]       o_digital_control,  // active control
	output logic                                      o_cal_threshold_enable, // threshold on
	output logic      [irq_sync_pkg::REG_W-1:0]       o_cal_threshold_a,  // active threshold a
	output logic      [irq_sync_pkg::REG_W-1:0]       o_cal_threshold_b   // active threshold b
);
	localparam int RW = irq_sync_pkg::REG_W;
	localparam int IW = irq_sync_pkg::IDX_W;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                                   aw_held;
		logic [irq_sync_pkg::AXI_ADDR_W-1:0]    aw_addr;
		logic                                   w_held;
		logic [RW-1:0]                          wdata;
		logic                                   wlane;
		logic                                   bvalid;
		logic [1:0]                             bresp;
		logic                                   rvalid;
		logic [RW-1:0]                          rdata;
		logic [1:0]                             rresp;
		logic [RW-1:0]                          clock_ratio;
		logic [RW-1:0]                          scratch;
		logic                                   transfer;
		logic [RW-1:0]                          mask;
		logic [RW-1:0]                          pending;
		logic [RW-1:0]                          dig_ctrl;
		logic [RW-1:0]                          cal_ctrl;
		logic [RW-1:0]                          cal_a;
		logic [RW-1:0]                          cal_b;
		logic [RW-1:0]                          sysref_ctrl;
		logic                                   err_hold;
		logic                                   err_setup;
		logic                                   err_clock;
		logic [RW-1:0]                          act_ratio;
		logic [RW-1:0]                          act_dig;
		logic [RW-1:0]                          act_cal_ctrl;
		logic [RW-1:0]                          act_cal_a;
		logic [RW-1:0]                          act_cal_b;
		logic                                   irq;
	} regs_state_type;

	regs_state_type s;
	regs_state_type next_s;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic [IW-1:0] addr_index(input logic [irq_sync_pkg::AXI_ADDR_W-1:0] a);
		addr_index = a[IW+1:2];
	endfunction

	// unaligned addresses and holes answer with a slave error
	function automatic logic is_mapped(input logic [irq_sync_pkg::AXI_ADDR_W-1:0] a);
		logic [IW-1:0] idx;
		idx = a[IW+1:2];
		if (a[1:0] != 2'h0 || a[irq_sync_pkg::AXI_ADDR_W-1:IW+2] != '0) begin
			is_mapped = 1'b0;
		end else begin
			unique case (idx)
				irq_sync_pkg::IDX_SYSREF_CONTROL,
				irq_sync_pkg::IDX_CLOCK_RATIO,
				irq_sync_pkg::IDX_SCRATCH_SPARE,
				irq_sync_pkg::IDX_SHADOW_TRANSFER,
				irq_sync_pkg::IDX_IRQ_STATUS,
				irq_sync_pkg::IDX_IRQ_MASK,
				irq_sync_pkg::IDX_IRQ_PENDING,
				irq_sync_pkg::IDX_DIGITAL_CONTROL,
				irq_sync_pkg::IDX_CAL_THRESH_CTRL,
				irq_sync_pkg::IDX_CAL_THRESH_A,
				irq_sync_pkg::IDX_CAL_THRESH_B: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// event inputs cross from outside the clock domain
	// ----------------------------------------------------------------
	logic [3:0] ev_sync;
	logic       ev_pll;
	logic       ev_hold;
	logic       ev_setup;
	logic       ev_clock;

	level_sync #(
		.WIDTH(4)
	) u_event_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_d      ({i_pll_unlocked, i_sysref_hold_err, i_sysref_setup_err, i_clock_err}),
		.o_q      (ev_sync)
	);

	assign ev_pll   = ev_sync[3];
	assign ev_hold  = ev_sync[2];
	assign ev_setup = ev_sync[1];
	assign ev_clock = ev_sync[0];

	// ----------------------------------------------------------------
	// live status view
	// ----------------------------------------------------------------
	logic [RW-1:0] status;

	always_comb begin
		status                                = '0;
		status[irq_sync_pkg::BIT_PLL_UNLOCK]   = ev_pll;
		status[irq_sync_pkg::BIT_SYSREF_HOLD]  = s.err_hold;
		status[irq_sync_pkg::BIT_SYSREF_SETUP] = s.err_setup;
		status[irq_sync_pkg::BIT_CLOCK_ERR]    = s.err_clock;
	end

	assign o_awready = !s.aw_held && !s.bvalid;
	assign o_wready  = !s.w_held && !s.bvalid;
	assign o_arready = !s.rvalid;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic          commit;
	logic [IW-1:0] widx;
	logic [IW-1:0] ridx;

	always_comb begin
		next_s = s;
		widx   = addr_index(s.aw_addr);
		ridx   = addr_index(i_araddr);
		commit = s.aw_held && s.w_held;

		if (i_awvalid && o_awready) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = i_awaddr;
		end
		if (i_wvalid && o_wready) begin
			next_s.w_held = 1'b1;
			next_s.wdata  = i_wdata[RW-1:0];
			next_s.wlane  = i_wstrb[0];
		end
		if (s.bvalid && i_bready) begin
			next_s.bvalid = 1'b0;
		end

		// transfer runs one cycle after the write, then the bit drops
		if (s.transfer) begin
			next_s.act_ratio    = s.clock_ratio;
			next_s.act_dig      = s.dig_ctrl;
			next_s.act_cal_ctrl = s.cal_ctrl;
			next_s.act_cal_a    = s.cal_a;
			next_s.act_cal_b    = s.cal_b;
			next_s.transfer     = 1'b0;
		end

		if (commit) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = is_mapped(s.aw_addr) ? irq_sync_pkg::RESP_OKAY
			                                      : irq_sync_pkg::RESP_SLVERR;
			if (is_mapped(s.aw_addr) && s.wlane) begin
				unique case (widx)
					irq_sync_pkg::IDX_CLOCK_RATIO: begin
						next_s.clock_ratio = s.wdata;
					end
					irq_sync_pkg::IDX_SCRATCH_SPARE: begin
						next_s.scratch = s.wdata;
					end
					irq_sync_pkg::IDX_SHADOW_TRANSFER: begin
						// writing zero leaves everything alone
						if (s.wdata[irq_sync_pkg::BIT_TRANSFER]) begin
							next_s.transfer = 1'b1;
						end
					end
					irq_sync_pkg::IDX_IRQ_MASK: begin
						next_s.mask = s.wdata & irq_sync_pkg::MASK_IRQ_MASK_RW;
					end
					irq_sync_pkg::IDX_IRQ_PENDING: begin
						next_s.pending = s.pending & ~s.wdata;
					end
					irq_sync_pkg::IDX_DIGITAL_CONTROL: begin
						next_s.dig_ctrl = s.wdata & irq_sync_pkg::MASK_DIGITAL_RW;
					end
					irq_sync_pkg::IDX_CAL_THRESH_CTRL: begin
						next_s.cal_ctrl = s.wdata & irq_sync_pkg::MASK_CAL_CTRL_RW;
					end
					irq_sync_pkg::IDX_CAL_THRESH_A: begin
						next_s.cal_a = s.wdata;
					end
					irq_sync_pkg::IDX_CAL_THRESH_B: begin
						next_s.cal_b = s.wdata;
					end
					irq_sync_pkg::IDX_SYSREF_CONTROL: begin
						next_s.sysref_ctrl = s.wdata & irq_sync_pkg::MASK_SYSREF_RW;
						// the falling half of a set-then-clear sequence wipes both flags
						if (s.sysref_ctrl[irq_sync_pkg::BIT_SYSREF_CLEAR]
						    && !s.wdata[irq_sync_pkg::BIT_SYSREF_CLEAR]) begin
							next_s.err_hold  = 1'b0;
							next_s.err_setup = 1'b0;
						end
					end
					default: begin
						// status is read only
					end
				endcase
			end
		end

		// sets come last so an error in the clearing cycle survives
		if (ev_hold) begin
			next_s.err_hold = 1'b1;
		end
		if (ev_setup) begin
			next_s.err_setup = 1'b1;
		end
		// nothing in the map clears this one
		if (ev_clock) begin
			next_s.err_clock = 1'b1;
		end
		next_s.pending = next_s.pending | (status & irq_sync_pkg::MASK_IRQ_BITS);
		next_s.irq     = |(next_s.pending & ~next_s.mask);

		if (s.rvalid && i_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (i_arvalid && o_arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = '0;
			next_s.rresp  = is_mapped(i_araddr) ? irq_sync_pkg::RESP_OKAY
			                                    : irq_sync_pkg::RESP_SLVERR;
			if (is_mapped(i_araddr)) begin
				unique case (ridx)
					irq_sync_pkg::IDX_SYSREF_CONTROL:  next_s.rdata = s.sysref_ctrl;
					irq_sync_pkg::IDX_CLOCK_RATIO:     next_s.rdata = s.clock_ratio;
					irq_sync_pkg::IDX_SCRATCH_SPARE:   next_s.rdata = s.scratch;
					irq_sync_pkg::IDX_SHADOW_TRANSFER: next_s.rdata = {7'h00, s.transfer};
					irq_sync_pkg::IDX_IRQ_STATUS:      next_s.rdata = status;
					irq_sync_pkg::IDX_IRQ_MASK:        next_s.rdata = s.mask;
					irq_sync_pkg::IDX_IRQ_PENDING:     next_s.rdata = s.pending;
					irq_sync_pkg::IDX_DIGITAL_CONTROL: next_s.rdata = s.dig_ctrl;
					irq_sync_pkg::IDX_CAL_THRESH_CTRL: next_s.rdata = s.cal_ctrl;
					irq_sync_pkg::IDX_CAL_THRESH_A:    next_s.rdata = s.cal_a;
					irq_sync_pkg::IDX_CAL_THRESH_B:    next_s.rdata = s.cal_b;
					default:                           next_s.rdata = '0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			s              <= '0;
			s.clock_ratio  <= irq_sync_pkg::RST_CLOCK_RATIO;
			s.scratch      <= irq_sync_pkg::RST_SCRATCH_SPARE;
			s.mask         <= irq_sync_pkg::RST_IRQ_MASK;
			s.dig_ctrl     <= irq_sync_pkg::RST_DIGITAL_CONTROL;
			s.cal_ctrl     <= irq_sync_pkg::RST_CAL_THRESH_CTRL;
			s.cal_a        <= irq_sync_pkg::RST_CAL_THRESH_A;
			s.cal_b        <= irq_sync_pkg::RST_CAL_THRESH_B;
			s.sysref_ctrl  <= irq_sync_pkg::RST_SYSREF_CONTROL;
			s.act_ratio    <= irq_sync_pkg::RST_CLOCK_RATIO;
			s.act_dig      <= irq_sync_pkg::RST_DIGITAL_CONTROL;
			s.act_cal_ctrl <= irq_sync_pkg::RST_CAL_THRESH_CTRL;
			s.act_cal_a    <= irq_sync_pkg::RST_CAL_THRESH_A;
			s.act_cal_b    <= irq_sync_pkg::RST_CAL_THRESH_B;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// divided clock, only the divide-by-four code runs it
	// ----------------------------------------------------------------
	logic ratio_ok;

	assign ratio_ok = (s.act_ratio[irq_sync_pkg::BIT_RATIO_SEL]
	                   == irq_sync_pkg::RATIO_SEL_DIV4);

	clock_divider #(
		.RATIO(irq_sync_pkg::DIV_RATIO_4)
	) u_divider (
		.i_clk     (i_clk),
		.i_resetn  (i_resetn),
		.i_enable  (ratio_ok),
		.o_div_clk (o_divided_clock_output)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_bvalid               = s.bvalid;
	assign o_bresp                = s.bresp;
	assign o_rvalid               = s.rvalid;
	assign o_rdata                = {{(irq_sync_pkg::AXI_DATA_W-RW){1'b0}}, s.rdata};
	assign o_rresp                = s.rresp;
	assign o_irq                  = s.irq;
	assign o_data_invalid         = s.err_clock;
	assign o_digital_control      = s.act_dig;
	assign o_cal_threshold_enable = s.act_cal_ctrl[irq_sync_pkg::BIT_CAL_THRESH_EN];
	assign o_cal_threshold_a      = s.act_cal_a;
	assign o_cal_threshold_b      = s.act_cal_b;
endmodule // irq_sync_regs
`default_nettype wire

// ### hw/level_sync.sv
// two flip-flop synchroniser for a group of levels
`default_nettype none
module level_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             i_clk,    // clock
	input  wire logic             i_resetn, // sync reset, active low
	input  wire logic [WIDTH-1:0] i_d,      // asynchronous levels
	output logic      [WIDTH-1:0] o_q       // synchronised levels
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_type;

	sync_state_type s;
	sync_state_type next_s;

	// stage1 is only ever read by stage2
	always_comb begin
		next_s        = s;
		next_s.stage1 = i_d;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_q = s.stage2;
endmodule // level_sync
`default_nettype wire

// ### tb/host_bus_model.sv
// host model: register bus master, one access at a time
`default_nettype none
module host_bus_model (
	input  wire logic        i_clk,     // clock
	input  wire logic        i_awready, // aw taken
	input  wire logic        i_wready,  // w taken
	input  wire logic        i_arready, // ar taken
	input  wire logic        i_bvalid,  // write answer
	input  wire logic [1:0]  i_bresp,   // write code
	input  wire logic        i_rvalid,  // read answer
	input  wire logic [31:0] i_rdata,   // read word
	input  wire logic [1:0]  i_rresp,   // read code
	output logic             o_awvalid, // aw offer
	output logic      [11:0] o_awaddr,  // aw address
	output logic             o_wvalid,  // w offer
	output logic      [31:0] o_wdata,   // w word
	output logic      [3:0]  o_wstrb,   // w strobes
	output logic             o_bready,  // b accept
	output logic             o_arvalid, // ar offer
	output logic      [11:0] o_araddr,  // ar address
	output logic             o_rready,  // r accept
	output logic             o_hang     // no answer in time
);
	initial begin
		{o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready, o_hang} = '0;
		{o_awaddr, o_araddr, o_wdata, o_wstrb} = '0;
	end
	// handshakes are judged at the falling edge so that combinational
	// readies are seen before the rising edge that takes them
	task automatic xfer(input logic rd, input logic [8:0] idx, input logic [7:0] d,
		output logic [31:0] q, output logic [1:0] rs);
		logic aw, w, ar, fin;
		fin = 1'b0;
		@(posedge i_clk);
		o_awaddr <= {1'b0, idx, 2'h0};
		o_araddr <= {1'b0, idx, 2'h0};
		o_wdata <= {24'h0, d};
		o_wstrb <= 4'hF;
		{o_awvalid, o_wvalid, o_bready} <= {3{!rd}};
		{o_arvalid, o_rready} <= {2{rd}};
		for (int n = 0; n < 64 && !fin; n++) begin
			@(negedge i_clk);
			aw = i_awready;
			w = i_wready;
			ar = i_arready;
			fin = rd ? i_rvalid : i_bvalid;
			q = i_rdata;
			rs = rd ? i_rresp : i_bresp;
			@(posedge i_clk);
			if (aw) o_awvalid <= 1'b0;
			if (w) o_wvalid <= 1'b0;
			if (ar) o_arvalid <= 1'b0;
		end
		{o_bready, o_rready} <= 2'h0;
		o_hang <= !fin;
	endtask
endmodule // host_bus_model
`default_nettype wire

// ### tb/irq_and_sync_control_regs_test.sv
// self-checking bench for the control register slice
`default_nettype none
module irq_and_sync_control_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, o_data_invalid;
	logic o_divided_clock_output, o_cal_threshold_enable, hang;
	logic i_pll_unlocked, i_sysref_setup_err, i_sysref_hold_err, i_clock_err;
	logic [11:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata, q;
	logic [3:0]  i_wstrb;
	logic [1:0]  o_bresp, o_rresp, rs;
	logic [7:0]  o_digital_control, o_cal_threshold_a, o_cal_threshold_b;
	int mismatches, comparisons, highs;
	irq_sync_regs dut (.i_clk, .i_resetn, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
		.o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
		.o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_pll_unlocked,
		.i_sysref_setup_err, .i_sysref_hold_err, .i_clock_err, .o_irq,
		.o_divided_clock_output, .o_data_invalid, .o_digital_control,
		.o_cal_threshold_enable, .o_cal_threshold_a, .o_cal_threshold_b);
	host_bus_model host (.i_clk, .i_awready(o_awready), .i_wready(o_wready), .i_arready(o_arready),
		.i_bvalid(o_bvalid), .i_bresp(o_bresp), .i_rvalid(o_rvalid), .i_rdata(o_rdata),
		.i_rresp(o_rresp), .o_awvalid(i_awvalid), .o_awaddr(i_awaddr), .o_wvalid(i_wvalid),
		.o_wdata(i_wdata), .o_wstrb(i_wstrb), .o_bready(i_bready), .o_arvalid(i_arvalid),
		.o_araddr(i_araddr), .o_rready(i_rready), .o_hang(hang));
	always #5 i_clk = ~i_clk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic give_verdict;
		if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [8:0] idx, input logic [7:0] d);
		host.xfer(1'b0, idx, d, q, rs);
		chk(32'(rs), 32'h0);
	endtask
	task automatic rd(input logic [8:0] idx, input logic [7:0] e);
		host.xfer(1'b1, idx, 8'h00, q, rs);
		chk(q, 32'(e));
	endtask
	// events are held long enough to pass the two-stage synchroniser
	task automatic ev(input logic [3:0] v);
		@(posedge i_clk);
		{i_pll_unlocked, i_sysref_setup_err, i_sysref_hold_err, i_clock_err} <= v;
		repeat (6) @(negedge i_clk);
	endtask
	task automatic do_reset;
		@(posedge i_clk);
		i_resetn <= 1'b0;
		repeat (8) @(posedge i_clk);
		i_resetn <= 1'b1;
	endtask
	always @(posedge hang) begin
		mismatches++;
		$display("FAIL %0t bus answer missing", $time);
		give_verdict;
	end
	initial begin
		{i_clk, i_resetn, i_pll_unlocked, i_sysref_setup_err} = '0;
		{i_sysref_hold_err, i_clock_err} = '0;
		do_reset;
		repeat (4) begin
			@(negedge i_clk);
			highs += o_divided_clock_output;
		end
		chk(highs, 32'h2);
		rd(9'h0F8, 8'h00);
		rd(9'h0FF, 8'h00);
		rd(9'h100, 8'h00);
		rd(9'h10A, 8'h10);
		rd(9'h10D, 8'h3D);
		rd(9'h10E, 8'h14);
		chk(32'(o_cal_threshold_enable), 32'h1);
		wr(9'h10D, 8'hA5);
		wr(9'h10A, 8'h00);
		wr(9'h0FF, 8'h00);
		chk(32'(o_cal_threshold_a), 32'h3D);
		wr(9'h0FF, 8'h01);
		repeat (2) @(negedge i_clk);
		chk(32'(o_cal_threshold_a), 32'hA5);
		chk(32'(o_cal_threshold_enable), 32'h0);
		chk(32'(o_cal_threshold_b), 32'h14);
		chk(32'(o_digital_control), 32'h00);
		rd(9'h0FF, 8'h00);
		ev(4'h8);
		rd(9'h100, 8'h80);
		chk(32'(o_irq), 32'h1);
		wr(9'h101, 8'h80);
		@(negedge i_clk);
		chk(32'(o_irq), 32'h0);
		ev(4'h0);
		rd(9'h100, 8'h00);
		wr(9'h101, 8'h0C);
		wr(9'h102, 8'hFF);
		ev(4'h2);
		ev(4'h0);
		rd(9'h100, 8'h08);
		chk(32'(o_irq), 32'h0);
		ev(4'h4);
		ev(4'h0);
		rd(9'h100, 8'h0C);
		wr(9'h03A, 8'h40);
		rd(9'h100, 8'h0C);
		wr(9'h03A, 8'h00);
		rd(9'h100, 8'h00);
		wr(9'h101, 8'h00);
		wr(9'h102, 8'hFF);
		ev(4'h1);
		ev(4'h0);
		rd(9'h100, 8'h01);
		chk(32'(o_irq), 32'h1);
		wr(9'h101, 8'h01);
		@(negedge i_clk);
		chk(32'(o_irq), 32'h0);
		wr(9'h100, 8'h00);
		rd(9'h100, 8'h01);
		chk(32'(o_data_invalid), 32'h1);
		wr(9'h101, 8'hFF);
		rd(9'h101, 8'hBD);
		host.xfer(1'b1, 9'h0FA, 8'h00, q, rs);
		chk(32'(rs), 32'h2);
		do_reset;
		rd(9'h100, 8'h00);
		chk(32'(o_data_invalid), 32'h0);
		give_verdict;
	end
endmodule // irq_and_sync_control_regs_test
bind irq_sync_regs irq_sync_regs_monitor mon (.i_clk, .i_resetn, .i_awvalid, .o_awready,
	.i_wvalid, .o_wready, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rvalid,
	.i_rready, .i_clock_err, .o_divided_clock_output, .o_data_invalid);
`default_nettype wire

// ### tb/irq_sync_regs_monitor.sv
// checker for the control register slice
`default_nettype none
module irq_sync_regs_monitor (
	input wire logic i_clk,                  // clock
	input wire logic i_resetn,               // reset, low
	input wire logic i_awvalid,              // aw offer
	input wire logic o_awready,              // aw taken
	input wire logic i_wvalid,               // w offer
	input wire logic o_wready,               // w taken
	input wire logic o_bvalid,               // write answer
	input wire logic i_bready,               // b accept
	input wire logic i_arvalid,              // ar offer
	input wire logic o_arready,              // ar taken
	input wire logic o_rvalid,               // read answer
	input wire logic i_rready,               // r accept
	input wire logic i_clock_err,            // clock fault
	input wire logic o_divided_clock_output, // divided clock
	input wire logic o_data_invalid          // data not trusted
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	AST_W_LAT: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
		else $error("write answer not two edges after offer");
	AST_R_LAT: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read answer late");
	AST_AR_BUSY: assert property (o_rvalid |-> !o_arready)
		else $error("read address taken while answer pending");
	AST_W_BUSY: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("write taken while answer pending");
	AST_B_DROP: assert property (o_bvalid && i_bready |=> !o_bvalid)
		else $error("write answer repeated");
	AST_R_DROP: assert property (o_rvalid && i_rready |=> !o_rvalid)
		else $error("read answer repeated");
	AST_DIV_FOUR: assert property ($rose(o_divided_clock_output) |->
		##1 o_divided_clock_output ##1 !o_divided_clock_output[*2] ##1 o_divided_clock_output)
		else $error("divided clock not two high two low");
	AST_INV_STICKY: assert property (o_data_invalid |=> o_data_invalid)
		else $error("data invalid dropped without reset");
	AST_INV_CAUSE: assert property (i_clock_err[*4] |-> ##[0:2] o_data_invalid)
		else $error("clock fault not reported");
endmodule // irq_sync_regs_monitor
`default_nettype wire
